// [src/nfb_pkg.sv]
// shared constants and types for the network fifo byte-order block
`default_nettype none
package nfb_pkg;

  localparam int          FIFO_BYTES  = 32;
  localparam int          FIFO_DEPTH  = 8;
  localparam int          LANES       = 4;
  localparam int          PTR_W       = 5;
  localparam int          CNT_W       = 6;
  localparam logic [5:0]  CNT_FULL    = 6'h20;
  localparam logic [5:0]  CNT_ONE     = 6'h01;
  localparam logic [5:0]  CNT_TWO     = 6'h02;
  localparam logic [7:0]  FILL_BYTE   = 8'hFF;
  localparam logic [3:0]  BE_LOW      = 4'h3;
  localparam logic [3:0]  BE_HIGH     = 4'hC;
  localparam logic [1:0]  LANE_TOP    = 2'h3;
  // threshold codes 0..3 select 2, 4, 6 or 8 words of 16 bits
  localparam logic [5:0]  THR_STEP_B  = 6'h04;
  localparam logic [5:0]  THR_BASE_B  = 6'h04;

  typedef struct packed {
    logic       byte_order_select;
    logic       block_mode_select;
    logic [1:0] rx_fifo_threshold;
    logic [1:0] tx_fifo_threshold;
  } nfb_cfg_t;

  typedef enum logic [2:0] {
    RX_DATA, RX_FILL, RX_STAT0, RX_STAT1, RX_SKIP
  } nfb_rx_state_t;

  // threshold in bytes
  function automatic logic [5:0] thr_bytes(input logic [1:0] code);
    thr_bytes = THR_BASE_B + 6'(code) * THR_STEP_B;
  endfunction

  // byte lane of a byte pointer for the selected byte order
  function automatic logic [1:0] lane_of(input logic [4:0] ptr,
                                         input logic       big);
    lane_of = big ? LANE_TOP - ptr[1:0] : ptr[1:0];
  endfunction

  // upper half of the entry holds the word of a byte pointer
  function automatic logic half_of(input logic [4:0] ptr,
                                   input logic       big);
    half_of = big ? ~ptr[1] : ptr[1];
  endfunction

endpackage
`default_nettype wire

// [src/nfb_lane_mem.sv]
// four-lane fifo storage with byte enables and one read port
`timescale 1ns/10ps
`default_nettype none
module nfb_lane_mem
  import nfb_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
)
(
  // clock
  input  wire logic                     ref_clk,
  // write side
  input  wire logic                     wr_en,
  input  wire logic [$clog2(DEPTH)-1:0] wr_entry,
  input  wire logic [LANES-1:0]         wr_be,
  input  wire logic [8*LANES-1:0]       wr_data,
  // read side
  input  wire logic [$clog2(DEPTH)-1:0] rd_entry,
  output var  logic [8*LANES-1:0]       rd_data
);

  // entry index must cover the depth exactly, so powers of two only
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
  begin : g_bad_depth
    $error("nfb_lane_mem: depth must be a power of two");
  end

  logic [8*LANES-1:0] mem [DEPTH];

  // storage holds no reset; occupancy is tracked by the owner
  always_ff @(posedge ref_clk)
  begin
    for (int i = 0; i < LANES; i++)
      if (wr_en && wr_be[i])
        mem[wr_entry][8*i +: 8] <= wr_data[8*i +: 8];
  end

  always_comb
  begin
    rd_data = mem[rd_entry];
  end

endmodule
`default_nettype wire

// [src/nfb_fifo_ctrl.sv]
// receive and transmit fifos with byte ordering and dma requests
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// RULE1: order select low puts byte 0 in bits 7:0, byte 1 in 15:8.
// RULE2: order select high puts byte 0 in bits 15:8, byte 1 in 7:0.
// RULE3: two independent 32-byte fifos, receive and transmit.
// RULE4: block mode select picks block or empty/fill transfers.
// RULE5: empty/fill moves enough to fill tx or empty rx fifo.
// RULE6: rx fifo is 8 x 4 bytes, bytes steered by order-aware pointer.
// RULE7: rx threshold sets fill level before a dma request.
// RULE8: rx threshold reached only when byte count exceeds it.
// RULE9: dma engine moves upper or lower 16-bit half per rx access.
// RULE10: request again while count still exceeds threshold, else stop; code keeps requesting after a packet end until the fifo is empty.
// RULE11: block mode rx request moves exactly threshold bytes; code moves the rest when a flush leaves count at or below it.
// RULE12: packet ending mid-word is padded with 0xFF fill bytes.
// RULE13: packet status written right after last data or fill byte.
// RULE14: rx data leaves only as whole words on word boundaries.
// RULE15: engine writes 16-bit words into upper or lower tx half.
// RULE16: tx reading starts only when count exceeds threshold; code also starts once fetch ends with bytes left.
// RULE17: tx request raised while count at or below threshold.
// RULE18: block mode loads threshold bytes; empty/fill fills fully.
// RULE19: tx reads bytes by order-aware pointer and tracks count.
// RULE20: extraneous tx bytes are skipped, only valid bytes serialized.
// RULE21: tx data may start at any byte address.
// RULE22: host-visible control words are 16 bits wide.
// RULE23: rx byte into a full fifo flags overrun and drops packet; code drops everything buffered, earlier packets too.
// RULE24: each fifo keeps a 0 to 32 byte occupancy count.
module nfb_fifo_ctrl
  import nfb_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // static configuration
  input  wire nfb_cfg_t    cfg,
  // receive, from deserializer
  input  wire logic        rx_byte_valid,
  input  wire logic [7:0]  rx_byte,
  input  wire logic        rx_pkt_end,
  input  wire logic [15:0] rx_status,
  output var  logic        rx_ready,
  output var  logic        rx_overrun,
  // receive, to dma engine
  output var  logic        rx_dma_req,
  output var  logic [4:0]  rx_burst_words,
  input  wire logic        rx_dma_rd,
  output var  logic [15:0] rx_dma_data,
  // transmit, from dma engine
  input  wire logic        tx_pkt_start,
  output var  logic        tx_dma_req,
  output var  logic [4:0]  tx_burst_words,
  input  wire logic        tx_dma_wr,
  input  wire logic [15:0] tx_dma_data,
  input  wire logic [1:0]  tx_dma_byte_valid,
  input  wire logic        tx_dma_last,
  // transmit, to serializer
  input  wire logic        tx_ser_ready,
  output var  logic        tx_ser_valid,
  output var  logic [7:0]  tx_ser_byte
);

  //////////////////////////////////////////////////////////////////////////
  // receive side

  nfb_rx_state_t rx_state, next_rx_state;
  logic [4:0]    rx_wr_ptr, next_rx_wr_ptr;
  logic [4:0]    rx_rd_ptr, next_rx_rd_ptr;
  logic [5:0]    rx_count, next_rx_count;
  logic [15:0]   rx_stat, next_rx_stat;
  logic          rx_flush, next_rx_flush;
  logic          next_rx_ready;
  logic          next_rx_overrun;
  logic          next_rx_dma_req;
  logic [4:0]    next_rx_burst_words;
  logic [15:0]   next_rx_dma_data;
  logic          rx_we;
  logic [7:0]    rx_wbyte;
  logic [31:0]   rx_rword;
  logic [5:0]    rx_thr;
  logic          big;

  assign big    = cfg.byte_order_select;
  assign rx_thr = thr_bytes(cfg.rx_fifo_threshold);

  nfb_lane_mem #(.DEPTH(FIFO_DEPTH)) u_rx_mem  // [RULE3]
  (
    .ref_clk  (ref_clk),
    .wr_en    (rx_we),
    .wr_entry (rx_wr_ptr[4:2]),
    .wr_be    (4'(1) << lane_of(rx_wr_ptr, big)),  // [RULE6]
    .wr_data  ({LANES{rx_wbyte}}),
    .rd_entry (rx_rd_ptr[4:2]),
    .rd_data  (rx_rword)
  );

  always_comb
  begin
    next_rx_state   = rx_state;
    next_rx_wr_ptr  = rx_wr_ptr;
    next_rx_rd_ptr  = rx_rd_ptr;
    next_rx_count   = rx_count;
    next_rx_stat    = rx_stat;
    next_rx_flush   = rx_flush;
    next_rx_overrun = 1'b0;
    next_rx_dma_data = rx_dma_data;
    rx_we           = 1'b0;
    rx_wbyte        = rx_byte;
    case (rx_state)
      RX_DATA:
        if (rx_pkt_end)
        begin
          next_rx_stat  = rx_status;  // [RULE22]
          next_rx_state = rx_wr_ptr[0] ? RX_FILL : RX_STAT0;  // [RULE12]
        end
        else if (rx_byte_valid)
          rx_we = 1'b1;
      RX_FILL:
      begin
        rx_we         = 1'b1;
        rx_wbyte      = FILL_BYTE;  // [RULE12]
        next_rx_state = RX_STAT0;
      end
      RX_STAT0:
      begin
        rx_we         = 1'b1;
        rx_wbyte      = rx_stat[7:0];  // [RULE13]
        next_rx_state = RX_STAT1;
      end
      RX_STAT1:
      begin
        rx_we         = 1'b1;
        rx_wbyte      = rx_stat[15:8];  // [RULE13]
        next_rx_state = RX_DATA;
        next_rx_flush = 1'b1;
      end
      RX_SKIP:
        if (rx_pkt_end)
          next_rx_state = RX_DATA;
      default:
        next_rx_state = RX_DATA;
    endcase
    // half-word read by the engine, data registered for next cycle
    if (rx_dma_rd)
    begin
      next_rx_dma_data = half_of(rx_rd_ptr, big) ? rx_rword[31:16]
                                                 : rx_rword[15:0];  // [RULE9]
      next_rx_rd_ptr   = rx_rd_ptr + 5'(CNT_TWO);  // [RULE14]
      next_rx_count    = next_rx_count - CNT_TWO;
    end
    if (rx_we)
    begin
      if (rx_count == CNT_FULL && !rx_dma_rd)
      begin
        // drop everything buffered in the fifo, earlier packets too, rather than a torn frame
        rx_we           = 1'b0;
        next_rx_overrun = 1'b1;  // [RULE23]
        next_rx_state   = RX_SKIP;
        next_rx_rd_ptr  = rx_wr_ptr;
        next_rx_count   = '0;
        next_rx_flush   = 1'b0;
      end
      else
      begin
        next_rx_wr_ptr = rx_wr_ptr + 5'(CNT_ONE);
        next_rx_count  = next_rx_count + CNT_ONE;  // [RULE24]
      end
    end
    if (rx_flush && next_rx_count == '0)
      next_rx_flush = 1'b0;
    // request follows the fifo level it is computed from
    next_rx_dma_req = (next_rx_count > rx_thr) ||
                      (next_rx_flush && next_rx_count != '0);  // [RULE8]
    if (cfg.block_mode_select && next_rx_count > rx_thr)  // [RULE4]
      next_rx_burst_words = rx_thr[5:1];  // [RULE11]
    else
      next_rx_burst_words = next_rx_count[5:1];  // [RULE5]
    next_rx_ready = (next_rx_state == RX_DATA) && !rx_pkt_end;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      rx_state       <= RX_DATA;
      rx_wr_ptr      <= '0;
      rx_rd_ptr      <= '0;
      rx_count       <= '0;
      rx_stat        <= '0;
      rx_flush       <= 1'b0;
      rx_ready       <= 1'b0;
      rx_overrun     <= 1'b0;
      rx_dma_req     <= 1'b0;
      rx_burst_words <= '0;
      rx_dma_data    <= '0;
    end
    else
    begin
      rx_state       <= next_rx_state;
      rx_wr_ptr      <= next_rx_wr_ptr;
      rx_rd_ptr      <= next_rx_rd_ptr;
      rx_count       <= next_rx_count;
      rx_stat        <= next_rx_stat;
      rx_flush       <= next_rx_flush;
      rx_ready       <= next_rx_ready;
      rx_overrun     <= next_rx_overrun;
      rx_dma_req     <= next_rx_dma_req;  // [RULE7] [RULE10]
      rx_burst_words <= next_rx_burst_words;
      rx_dma_data    <= next_rx_dma_data;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // transmit side

  logic [4:0]  tx_wr_ptr, next_tx_wr_ptr;
  logic [4:0]  tx_rd_ptr, next_tx_rd_ptr;
  logic [5:0]  tx_count, next_tx_count;
  logic [31:0] tx_vld, next_tx_vld;
  logic        tx_fetch, next_tx_fetch;
  logic        tx_started, next_tx_started;
  logic        next_tx_dma_req;
  logic [4:0]  next_tx_burst_words;
  logic        next_tx_ser_valid;
  logic [7:0]  next_tx_ser_byte;
  logic [31:0] tx_rword;
  logic [5:0]  tx_thr;
  logic        tx_take;

  assign tx_thr = thr_bytes(cfg.tx_fifo_threshold);

  nfb_lane_mem #(.DEPTH(FIFO_DEPTH)) u_tx_mem  // [RULE3]
  (
    .ref_clk  (ref_clk),
    .wr_en    (tx_dma_wr),
    .wr_entry (tx_wr_ptr[4:2]),
    .wr_be    (half_of(tx_wr_ptr, big) ? BE_HIGH : BE_LOW),  // [RULE15]
    .wr_data  ({2{tx_dma_data}}),  // [RULE1] [RULE2]
    .rd_entry (tx_rd_ptr[4:2]),
    .rd_data  (tx_rword)
  );

  always_comb
  begin
    next_tx_wr_ptr    = tx_wr_ptr;
    next_tx_rd_ptr    = tx_rd_ptr;
    next_tx_count     = tx_count;
    next_tx_vld       = tx_vld;
    next_tx_fetch     = tx_fetch;
    next_tx_started   = tx_started;
    next_tx_ser_valid = 1'b0;
    next_tx_ser_byte  = tx_ser_byte;
    if (tx_pkt_start)
      next_tx_fetch = 1'b1;
    if (tx_dma_wr)
    begin
      // odd start or end bytes are kept but marked invalid
      next_tx_vld[tx_wr_ptr]          = tx_dma_byte_valid[0];  // [RULE21]
      next_tx_vld[tx_wr_ptr + 5'h01]  = tx_dma_byte_valid[1];
      next_tx_wr_ptr = tx_wr_ptr + 5'(CNT_TWO);
      next_tx_count  = next_tx_count + CNT_TWO;
      if (tx_dma_last)
        next_tx_fetch = 1'b0;
    end
    // invalid bytes drain without waiting for the serializer
    tx_take = tx_started && tx_count != '0 &&
              (tx_ser_ready || !tx_vld[tx_rd_ptr]);
    if (tx_take)
    begin
      next_tx_ser_valid = tx_vld[tx_rd_ptr];  // [RULE20]
      next_tx_ser_byte = tx_rword[8*lane_of(tx_rd_ptr, big) +: 8]; // [RULE19]
      next_tx_rd_ptr    = tx_rd_ptr + 5'(CNT_ONE);
      next_tx_count     = next_tx_count - CNT_ONE;  // [RULE24]
    end
    // a short packet starts once its fetch has finished
    if (next_tx_count > tx_thr || (!next_tx_fetch && next_tx_count != '0))
      next_tx_started = 1'b1;  // [RULE16]
    else if (next_tx_count == '0)
      next_tx_started = 1'b0;
    next_tx_dma_req = next_tx_fetch && next_tx_count <= tx_thr;  // [RULE17]
    if (cfg.block_mode_select)
      next_tx_burst_words = tx_thr[5:1];  // [RULE18]
    else
      next_tx_burst_words = 5'((CNT_FULL - next_tx_count) >> 1);  // [RULE5]
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      tx_wr_ptr      <= '0;
      tx_rd_ptr      <= '0;
      tx_count       <= '0;
      tx_vld         <= '0;
      tx_fetch       <= 1'b0;
      tx_started     <= 1'b0;
      tx_dma_req     <= 1'b0;
      tx_burst_words <= '0;
      tx_ser_valid   <= 1'b0;
      tx_ser_byte    <= '0;
    end
    else
    begin
      tx_wr_ptr      <= next_tx_wr_ptr;
      tx_rd_ptr      <= next_tx_rd_ptr;
      tx_count       <= next_tx_count;
      tx_vld         <= next_tx_vld;
      tx_fetch       <= next_tx_fetch;
      tx_started     <= next_tx_started;
      tx_dma_req     <= next_tx_dma_req;
      tx_burst_words <= next_tx_burst_words;
      tx_ser_valid   <= next_tx_ser_valid;
      tx_ser_byte    <= next_tx_ser_byte;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks

  property p_rx_req;
    @(posedge ref_clk) disable iff (rst)
    (rx_count > rx_thr) |-> rx_dma_req;
  endproperty
  a_rx_req: assert property (p_rx_req)  // [RULE8]
    else $error("rx request missing above threshold");

  property p_rx_block;
    @(posedge ref_clk) disable iff (rst)
    (rx_dma_req && cfg.block_mode_select && rx_count > rx_thr)
      |-> rx_burst_words == rx_thr[5:1];
  endproperty
  a_rx_block: assert property (p_rx_block)  // [RULE11]
    else $error("block burst not equal to threshold");

  property p_rx_cnt;
    @(posedge ref_clk) disable iff (rst)
    rx_count <= CNT_FULL && tx_count <= CNT_FULL;
  endproperty
  a_rx_cnt: assert property (p_rx_cnt)  // [RULE24]
    else $error("fifo count above capacity");

  property p_rx_align;
    @(posedge ref_clk) disable iff (rst)
    (rx_state == RX_FILL) |=> (rx_state == RX_STAT0 && !rx_wr_ptr[0])
      or (rx_state == RX_SKIP);
  endproperty
  a_rx_align: assert property (p_rx_align)  // [RULE12]
    else $error("fill did not reach word boundary");

  property p_rx_stat;
    @(posedge ref_clk) disable iff (rst)
    (rx_state == RX_DATA && rx_pkt_end)
      |-> ##[1:2] (rx_state == RX_STAT0) ##1 (rx_state == RX_STAT1)
      or ##[1:3] (rx_state == RX_SKIP);
  endproperty
  a_rx_stat: assert property (p_rx_stat)  // [RULE13]
    else $error("status not written after packet end");

  property p_rx_ovr;
    @(posedge ref_clk) disable iff (rst)
    (rx_state == RX_DATA && rx_byte_valid && !rx_pkt_end &&
     rx_count == CNT_FULL && !rx_dma_rd)
      |=> rx_overrun && rx_state == RX_SKIP && rx_count == '0;
  endproperty
  a_rx_ovr: assert property (p_rx_ovr)  // [RULE23]
    else $error("overrun not flagged on full fifo");

  property p_tx_start;
    @(posedge ref_clk) disable iff (rst)
    (!tx_started && tx_fetch && tx_count <= tx_thr)
      |=> !tx_ser_valid && (!tx_started || tx_count > tx_thr || !tx_fetch);
  endproperty
  a_tx_start: assert property (p_tx_start)  // [RULE16]
    else $error("tx read before threshold met");

  property p_tx_req;
    @(posedge ref_clk) disable iff (rst)
    (tx_fetch && tx_count <= tx_thr) |-> tx_dma_req;
  endproperty
  a_tx_req: assert property (p_tx_req)  // [RULE17]
    else $error("tx request missing at low level");

  property p_tx_fill;
    @(posedge ref_clk) disable iff (rst)
    (tx_dma_req && !cfg.block_mode_select)
      |-> 6'(tx_burst_words) == ((CNT_FULL - tx_count) >> 1);
  endproperty
  a_tx_fill: assert property (p_tx_fill)  // [RULE18]
    else $error("empty/fill burst does not fill fifo");

  property p_tx_skip;
    @(posedge ref_clk) disable iff (rst)
    (tx_started && tx_count != '0 && !tx_vld[tx_rd_ptr]) |=> !tx_ser_valid;
  endproperty
  a_tx_skip: assert property (p_tx_skip)  // [RULE20]
    else $error("extraneous byte passed to serializer");

endmodule
`default_nettype wire

// [tb/nfb_partner.sv]
// receive dma engine and serializer model facing the fifo block
`timescale 1ns/10ps
`default_nettype none
module nfb_partner
  import nfb_pkg::*;
(
  // clock, reset and pacing: 0 prompt, 1 slow, 2 receive reads held
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [1:0]  mode,
  // receive dma
  input  wire logic        rx_dma_req,
  input  wire logic [4:0]  rx_burst_words,
  output var  logic        rx_dma_rd,
  input  wire logic [15:0] rx_dma_data,
  // serializer
  output var  logic        tx_ser_ready,
  input  wire logic        tx_ser_valid,
  input  wire logic [7:0]  tx_ser_byte
);
  logic [15:0] rx_q[$];
  logic [7:0]  tx_q[$];
  logic [4:0]  left;
  logic [1:0]  hold;
  logic        rd_d;
  logic        tick;
  ////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      rx_dma_rd    <= 1'b0;
      tx_ser_ready <= 1'b0;
      left         <= 5'h00;
      hold         <= 2'h0;
      rd_d         <= 1'b0;
      tick         <= 1'b0;
      rx_q.delete();
      tx_q.delete();
    end
    else
    begin
      tick         <= ~tick;
      rd_d         <= rx_dma_rd;
      tx_ser_ready <= (mode != 2'h1) | tick;
      rx_dma_rd    <= 1'b0;
      // data lands one cycle after its read
      if (rd_d)
        rx_q.push_back(rx_dma_data);
      if (tx_ser_valid)
        tx_q.push_back(tx_ser_byte);
      if (left != 5'h00)
      begin
        // slow pacing leaves a gap between halfword reads
        if (mode != 2'h1 || tick)
        begin
          rx_dma_rd <= 1'b1;
          left      <= left - 5'h01;
        end
      end
      // request is stale right after a burst, so let it settle
      else if (hold != 2'h0)
        hold <= hold - 2'h1;
      else if (rx_dma_req && mode != 2'h2)
      begin
        left <= rx_burst_words;
        hold <= 2'h3;
      end
    end
endmodule
`default_nettype wire

// [tb/tb.sv]
// self-checking testbench for the network fifo byte-order block
`timescale 1ns/10ps
`default_nettype none
module tb
  import nfb_pkg::*;
;
  logic        ref_clk, rst, rx_byte_valid, rx_pkt_end, rx_ready;
  logic        rx_overrun, rx_dma_req, rx_dma_rd, tx_pkt_start;
  logic        tx_dma_req, tx_dma_wr, tx_dma_last, tx_ser_ready;
  logic        tx_ser_valid, ovr_seen;
  logic [7:0]  rx_byte, tx_ser_byte;
  logic [15:0] rx_status, rx_dma_data, tx_dma_data;
  logic [4:0]  rx_burst_words, tx_burst_words;
  logic [1:0]  tx_dma_byte_valid, mode;
  nfb_cfg_t    cfg;
  int          n_errors, comparisons;

  nfb_fifo_ctrl dut (.ref_clk, .rst, .cfg, .rx_byte_valid, .rx_byte,
    .rx_pkt_end, .rx_status, .rx_ready, .rx_overrun, .rx_dma_req,
    .rx_burst_words, .rx_dma_rd, .rx_dma_data, .tx_pkt_start,
    .tx_dma_req, .tx_burst_words, .tx_dma_wr, .tx_dma_data,
    .tx_dma_byte_valid, .tx_dma_last, .tx_ser_ready, .tx_ser_valid,
    .tx_ser_byte);
  nfb_partner partner (.ref_clk, .rst, .mode, .rx_dma_req,
    .rx_burst_words, .rx_dma_rd, .rx_dma_data, .tx_ser_ready,
    .tx_ser_valid, .tx_ser_byte);

  initial ref_clk = 1'b0;
  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk or posedge rst)
    if (rst)
      ovr_seen <= 1'b0;
    else if (rx_overrun === 1'b1)
      ovr_seen <= 1'b1;
  ////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic print_verdict;
    $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      n_errors++;
    end
  endtask
  task automatic check_flag(input logic got, input logic exp);
    check_word({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic give_up;
    $display("ERROR t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    n_errors++;
    print_verdict();
  endtask
  task automatic do_reset(input nfb_cfg_t c, input logic [1:0] m);
    int i;
    rst = 1'b1;
    cfg = c;
    mode = m;
    cyc(12);
    rst = 1'b0;
    // receive side needs one edge to open
    for (i = 0; i < 5 && rx_ready !== 1'b1; i++) cyc(1);
    if (rx_ready !== 1'b1) give_up();
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic send_bytes(input int first, input int n);
    int i;
    for (i = first; i < first + n; i++)
    begin
      rx_byte_valid = 1'b1;
      rx_byte = 8'(8'h10 + i);
      cyc(1);
    end
    rx_byte_valid = 1'b0;
  endtask
  task automatic end_pkt(input logic [15:0] st);
    rx_pkt_end = 1'b1;
    rx_status = st;
    cyc(1);
    rx_pkt_end = 1'b0;
  endtask
  task automatic wait_rx_req;
    int i;
    for (i = 0; i < 6 && rx_dma_req !== 1'b1; i++) cyc(1);
    check_flag(rx_dma_req, 1'b1);
  endtask
  // packet bytes, then fill, then status, paired into halfwords
  task automatic expect_rx(input int n, input logic [15:0] st,
                           input logic big);
    logic [7:0]  b[$];
    logic [15:0] w;
    int          i;
    for (i = 0; i < n; i++) b.push_back(8'(8'h10 + i));
    if (n % 2 == 1) b.push_back(FILL_BYTE);
    b.push_back(st[7:0]);
    b.push_back(st[15:8]);
    for (i = 0; i < 400 && partner.rx_q.size() < b.size() / 2; i++) cyc(1);
    check_word(16'(partner.rx_q.size()), 16'(b.size() / 2));
    for (i = 0; i / 2 < partner.rx_q.size() && i + 1 < b.size(); i += 2)
    begin
      w = big ? {b[i], b[i + 1]} : {b[i + 1], b[i]};
      check_word(partner.rx_q[i / 2], w);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic test_rx_order(input logic big);
    do_reset('{big, 1'b0, 2'h0, 2'h0}, 2'h0);
    send_bytes(0, 4);
    cyc(4);
    check_flag(rx_dma_req, 1'b0);
    send_bytes(4, 1);
    wait_rx_req();
    check_word(16'(rx_burst_words), 16'h0002);
    end_pkt(16'hA5C3);
    expect_rx(5, 16'hA5C3, big);
    $display("test rx order big=%0d done", big);
  endtask
  task automatic test_rx_block;
    do_reset('{1'b0, 1'b1, 2'h1, 2'h0}, 2'h1);
    send_bytes(0, 9);
    wait_rx_req();
    check_word(16'(rx_burst_words), 16'h0004);
    cyc(1);
    send_bytes(9, 11);
    end_pkt(16'h5A3C);
    expect_rx(20, 16'h5A3C, 1'b0);
    $display("test rx block done");
  endtask
  task automatic test_rx_overrun;
    do_reset('{1'b0, 1'b0, 2'h0, 2'h0}, 2'h2);
    send_bytes(0, 32);
    cyc(2);
    check_flag(ovr_seen, 1'b0);
    send_bytes(32, 1);
    cyc(2);
    check_flag(ovr_seen, 1'b1);
    end_pkt(16'h1234);
    mode = 2'h0;
    cyc(40);
    check_word(16'(partner.rx_q.size()), 16'h0000);
    $display("test rx overrun done");
  endtask
  ////////////////////////////////////////////////////////////////////////
  function automatic logic inpkt(input int e, input int a, input int n);
    return e >= a && e < a + n;
  endfunction
  function automatic logic [7:0] pbyte(input int e, input int a, input int n);
    // bytes outside the packet carry junk that must not appear
    return inpkt(e, a, n) ? 8'(8'h60 + e - a) : 8'hEE;
  endfunction
  task automatic test_tx(input logic big, input logic blk, input int a,
                         input int n);
    int         i, j, k, nb;
    logic [7:0] b0, b1;
    logic [4:0] nw;
    do_reset('{big, blk, 2'h0, 2'h0}, 2'h1);
    tx_pkt_start = 1'b1;
    cyc(1);
    tx_pkt_start = 1'b0;
    k = a / 2;
    nb = 0;
    while (k <= (a + n - 1) / 2)
    begin
      for (i = 0; i < 200 && tx_dma_req !== 1'b1; i++) cyc(1);
      if (tx_dma_req !== 1'b1) give_up();
      if (nb == 0)
        check_word(16'(tx_burst_words), blk ? 16'h0002 : 16'h0010);
      if (nb == 1 && blk)
        check_word(16'(partner.tx_q.size()), 16'h0000);
      nb++;
      // the burst size moves as writes land, so take it at the grant
      nw = tx_burst_words;
      for (j = 0; j < nw && k <= (a + n - 1) / 2; j++)
      begin
        b0 = pbyte(2 * k, a, n);
        b1 = pbyte(2 * k + 1, a, n);
        tx_dma_wr = 1'b1;
        tx_dma_data = big ? {b0, b1} : {b1, b0};
        tx_dma_byte_valid = {inpkt(2 * k + 1, a, n), inpkt(2 * k, a, n)};
        tx_dma_last = (k == (a + n - 1) / 2);
        k++;
        cyc(1);
      end
      tx_dma_wr = 1'b0;
      tx_dma_last = 1'b0;
      cyc(1);
    end
    for (i = 0; i < 400 && partner.tx_q.size() < n; i++) cyc(1);
    check_word(16'(partner.tx_q.size()), 16'(n));
    for (i = 0; i < n && i < partner.tx_q.size(); i++)
    begin
      b0 = pbyte(i + a, a, n);
      check_word({8'h00, partner.tx_q[i]}, {8'h00, b0});
    end
    $display("test tx big=%0d block=%0d start=%0d done", big, blk, a);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    n_errors = 0;
    comparisons = 0;
    rx_byte_valid = 1'b0;
    rx_byte = 8'h00;
    rx_pkt_end = 1'b0;
    rx_status = 16'h0000;
    tx_pkt_start = 1'b0;
    tx_dma_wr = 1'b0;
    tx_dma_data = 16'h0000;
    tx_dma_byte_valid = 2'h0;
    tx_dma_last = 1'b0;
    #1;
    test_rx_order(1'b0);
    test_rx_order(1'b1);
    test_rx_block();
    test_rx_overrun();
    test_tx(1'b0, 1'b1, 0, 37);
    test_tx(1'b1, 1'b1, 1, 36);
    test_tx(1'b0, 1'b0, 1, 37);
    test_tx(1'b1, 1'b0, 0, 33);
    print_verdict();
  end
endmodule
`default_nettype wire
